// [rtl/rbiws_pkg.sv]
// Purpose: constants and carriers of the reset, boot and wake sequencer
// Assumes: CLK is the input clock; one system cycle is one CLK cycle in bypass, two with the PLL on
// Notes: registers sit on AXI4-Lite, one 32-bit word each
package rbiws_pkg;
	// ****************************************************************
	// timing, in input clock periods
	// ****************************************************************
	localparam int unsigned CLK_PER_TCI = 1;
	localparam int unsigned LOCK_TCI = 131072;
	localparam int unsigned LOCK_CYC = LOCK_TCI * CLK_PER_TCI;
	localparam int unsigned WD_PULSE_TCI = 512;
	localparam logic [9:0] WD_PULSE_CYC = 10'(WD_PULSE_TCI * CLK_PER_TCI);
	localparam int unsigned EXT_BUS_TCI = 32;
	localparam logic [11:0] EXT_BUS_CYC = 12'(EXT_BUS_TCI * CLK_PER_TCI);
	// system clock counts, converted by the sequencer; last, the qualifier sample count, used as is
	localparam logic [11:0] BOOT_SYS = 12'h4EC;
	localparam logic [11:0] WAKE_FAST_SYS = 12'h008;
	localparam logic [11:0] WAKE_SLOW_SYS = 12'h41A;
	localparam logic [2:0] QUAL_SAMPLES = 3'h5;
	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PLLMUL = 8'h04;
	localparam logic [7:0] OFS_QUAL = 8'h08;
	localparam logic [7:0] OFS_EXTIF = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam int unsigned CTRL_IDLE_BIT = 0;
	localparam int unsigned CTRL_QUAL_BIT = 1;
	localparam int unsigned CTRL_FSLEEP_BIT = 2;
	localparam logic [1:0] EXTIF_RESET = 2'h3;
	localparam logic [3:0] PLLMUL_RESET = 4'h0;
	localparam logic [7:0] QUAL_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic reset_pin_n;
		logic nmi;
		logic pll_disable_strap;
		logic micro_mode_strap;
		logic [3:0] boot_mode;
	} rbiws_pins_type;
	typedef struct packed {
		logic [3:0] boot_mode;
		logic micro_mode;
		logic idle;
		logic boot_done;
		logic pll_disabled;
		logic pll_locked;
	} rbiws_status_type;
	typedef enum logic [2:0] {
		ST_RESET = 3'h0,
		ST_BOOT = 3'h1,
		ST_RUN = 3'h2,
		ST_IDLE = 3'h3,
		ST_WAKE = 3'h4
	} rbiws_state_type;
endpackage : rbiws_pkg

// [rtl/rbiws_sync3.sv]
// Purpose: three-stage pin synchroniser
// Assumes: inputs asynchronous to CLK
// Notes: a bit changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module rbiws_sync3 #(parameter int W = 8)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg, out_next;
	// stage one feeds stage two only
	always_comb
	begin
		out_next = (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			out_reg <= '0;
		end
		else
		begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= out_next;
		end
	end
	assign dout = out_reg;
endmodule : rbiws_sync3
`default_nettype wire

// [rtl/rbiws_qual.sv]
// Purpose: input qualifier for the wake pin
// Assumes: sample period given in CLK cycles
// Notes: output follows after six agreeing samples
`timescale 1ns/10ps
`default_nettype none
module rbiws_qual
(
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	input wire logic en,
	input wire logic [11:0] sp_cyc,
	output logic qout
);
	logic [11:0] tick_reg, tick_next;
	logic [2:0] same_reg, same_next;
	logic q_reg, q_next;
	// six samples one period apart, so the delay is 5*period + period
	always_comb
	begin
		tick_next = tick_reg;
		same_next = same_reg;
		q_next = q_reg;
		if (!en || sp_cyc == 12'h000)
		begin
			q_next = din;
			tick_next = 12'h000;
			same_next = 3'h0;
		end
		else if (tick_reg >= sp_cyc - 12'h001)
		begin
			tick_next = 12'h000;
			if (din == q_reg)
				same_next = 3'h0;
			else if (same_reg == rbiws_pkg::QUAL_SAMPLES)
			begin
				q_next = din;
				same_next = 3'h0;
			end
			else
				same_next = same_reg + 3'h1;
		end
		else
			tick_next = tick_reg + 12'h001;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tick_reg <= 12'h000;
			same_reg <= 3'h0;
			q_reg <= 1'b0;
		end
		else
		begin
			tick_reg <= tick_next;
			same_reg <= same_next;
			q_reg <= q_next;
		end
	end
	assign qout = q_reg;
	chk_qual_six_samples: assert property (@(posedge clk) disable iff (rst)
		(en && sp_cyc != 12'h000 && q_next != q_reg) |-> same_reg == 3'h5)
		else $error("qualified level changed before six samples");
endmodule : rbiws_qual
`default_nettype wire

// [rtl/rbiws_top.sv]
// Purpose: reset, boot sampling, PLL lock, clock out and idle wake sequencer
// Assumes: CLK is the input clock; pins pass the three-stage synchroniser
// Notes: registers over AXI4-Lite; the multiplier only drives the lock sequence
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rbiws_top #(parameter int unsigned LOCK_CYC = rbiws_pkg::LOCK_CYC)
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	input wire rbiws_pkg::rbiws_pins_type PINS,
	input wire logic ENABLED_IRQ,
	input wire logic WATCHDOG_INTERRUPT,
	input wire logic WATCHDOG_EXPIRE,
	output logic CORE_RESET,
	output logic EXT_BUS_VALID,
	output logic BOOT_SAMPLED,
	output logic [3:0] BOOT_MODE_OUT,
	output logic PLL_LOCKED,
	output logic CLOCK_OUT_PIN,
	output logic IDLE_ACTIVE,
	output logic RESUME
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	rbiws_pkg::rbiws_pins_type pins;
	logic nmi_q;
	logic [7:0] qual_reg, qual_next;
	logic [3:0] mult_reg, mult_next;
	logic [1:0] extif_reg, extif_next;
	logic qual_en_reg, qual_en_next, fsleep_reg, fsleep_next;
	logic idle_req_reg, idle_req_next;
	logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
	logic [7:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next, rdata_next;
	logic wstrb0_reg, wstrb0_next;
	logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
	logic [1:0] bresp_next, rresp_next;
	logic lock_busy_reg, lock_busy_next, locked_next;
	logic [17:0] lock_cnt_reg, lock_cnt_next;
	rbiws_pkg::rbiws_status_type status;
	// converts system cycles to CLK cycles: direct clock or half rate
	function automatic logic [11:0] sys_to_clk(input logic [11:0] n, input logic dis);
		sys_to_clk = dis ? n : {n[10:0], 1'b0};
	endfunction : sys_to_clk
	// ****************************************************************
	// pin synchroniser and wake qualifier
	// ****************************************************************
	rbiws_sync3 #(.W(8)) u_sync (.clk(CLK), .rst(RST), .din(PINS), .dout(pins));
	rbiws_qual u_qual (
		.clk(CLK),
		.rst(RST),
		.din(pins.nmi),
		.en(qual_en_reg),
		.sp_cyc(sys_to_clk({3'h0, qual_reg, 1'b0}, status.pll_disabled)),
		.qout(nmi_q)
	);
	// ****************************************************************
	// register bus and PLL lock
	// ****************************************************************
	// address and data are taken in either order; the write lands when both are held
	always_comb
	begin
		aw_have_next = aw_have_reg | (S_AXI_AWVALID & S_AXI_AWREADY);
		w_have_next = w_have_reg | (S_AXI_WVALID & S_AXI_WREADY);
		awaddr_next = (S_AXI_AWVALID & S_AXI_AWREADY) ? S_AXI_AWADDR : awaddr_reg;
		wdata_next = (S_AXI_WVALID & S_AXI_WREADY) ? S_AXI_WDATA : wdata_reg;
		wstrb0_next = (S_AXI_WVALID & S_AXI_WREADY) ? S_AXI_WSTRB[0] : wstrb0_reg;
		bvalid_next = S_AXI_BVALID & ~S_AXI_BREADY;
		bresp_next = S_AXI_BRESP;
		qual_next = qual_reg;
		mult_next = mult_reg;
		extif_next = extif_reg;
		qual_en_next = qual_en_reg;
		fsleep_next = fsleep_reg;
		idle_req_next = 1'b0;
		lock_busy_next = lock_busy_reg;
		lock_cnt_next = lock_busy_reg ? lock_cnt_reg + 18'h00001 : 18'h00000;
		if (lock_busy_reg && lock_cnt_reg == 18'(LOCK_CYC - 1))
			lock_busy_next = 1'b0;
		if (aw_have_reg && w_have_reg && !S_AXI_BVALID)
		begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = rbiws_pkg::RESP_OKAY;
			case (awaddr_reg)
				rbiws_pkg::OFS_CTRL:
					if (wstrb0_reg)
					begin
						idle_req_next = wdata_reg[rbiws_pkg::CTRL_IDLE_BIT];
						qual_en_next = wdata_reg[rbiws_pkg::CTRL_QUAL_BIT];
						fsleep_next = wdata_reg[rbiws_pkg::CTRL_FSLEEP_BIT];
					end
				rbiws_pkg::OFS_PLLMUL:
					// strap-disabled PLL ignores the multiplier
					if (wstrb0_reg && !status.pll_disabled)
					begin
						mult_next = wdata_reg[3:0];
						if (wdata_reg[3:0] != mult_reg && wdata_reg[3:0] != 4'h0)
						begin
							lock_busy_next = 1'b1;
							lock_cnt_next = 18'h00000;
						end
					end
				rbiws_pkg::OFS_QUAL:
					if (wstrb0_reg)
						qual_next = wdata_reg[7:0];
				rbiws_pkg::OFS_EXTIF:
					if (wstrb0_reg)
						extif_next = wdata_reg[1:0];
				rbiws_pkg::OFS_STATUS: ;
				default:
					bresp_next = rbiws_pkg::RESP_SLVERR;
			endcase
		end
		awready_next = ~aw_have_next;
		wready_next = ~w_have_next;
		rvalid_next = S_AXI_RVALID & ~S_AXI_RREADY;
		rdata_next = S_AXI_RDATA;
		rresp_next = S_AXI_RRESP;
		if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			rvalid_next = 1'b1;
			rresp_next = rbiws_pkg::RESP_OKAY;
			case (S_AXI_ARADDR)
				rbiws_pkg::OFS_CTRL: rdata_next = {29'h0, fsleep_reg, qual_en_reg, 1'b0};
				rbiws_pkg::OFS_PLLMUL: rdata_next = {28'h0, mult_reg};
				rbiws_pkg::OFS_QUAL: rdata_next = {24'h0, qual_reg};
				rbiws_pkg::OFS_EXTIF: rdata_next = {30'h0, extif_reg};
				rbiws_pkg::OFS_STATUS: rdata_next = {23'h0, status};
				default:
				begin
					rdata_next = 32'h0;
					rresp_next = rbiws_pkg::RESP_SLVERR;
				end
			endcase
		end
		arready_next = ~rvalid_next;
		locked_next = !status.pll_disabled && mult_next != 4'h0 && !lock_busy_next;
	end
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0;
			wstrb0_reg <= 1'b0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= rbiws_pkg::RESP_OKAY;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= rbiws_pkg::RESP_OKAY;
			qual_reg <= rbiws_pkg::QUAL_RESET;
			mult_reg <= rbiws_pkg::PLLMUL_RESET;
			extif_reg <= rbiws_pkg::EXTIF_RESET;
			qual_en_reg <= 1'b0;
			fsleep_reg <= 1'b0;
			idle_req_reg <= 1'b0;
			lock_busy_reg <= 1'b0;
			lock_cnt_reg <= 18'h00000;
			PLL_LOCKED <= 1'b0;
		end
		else
		begin
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb0_reg <= wstrb0_next;
			S_AXI_AWREADY <= awready_next;
			S_AXI_WREADY <= wready_next;
			S_AXI_BVALID <= bvalid_next;
			S_AXI_BRESP <= bresp_next;
			S_AXI_ARREADY <= arready_next;
			S_AXI_RVALID <= rvalid_next;
			S_AXI_RDATA <= rdata_next;
			S_AXI_RRESP <= rresp_next;
			qual_reg <= qual_next;
			mult_reg <= mult_next;
			extif_reg <= extif_next;
			qual_en_reg <= qual_en_next;
			fsleep_reg <= fsleep_next;
			idle_req_reg <= idle_req_next;
			lock_busy_reg <= lock_busy_next;
			lock_cnt_reg <= lock_cnt_next;
			PLL_LOCKED <= locked_next;
		end
	end
	// ****************************************************************
	// reset, boot and wake sequencer
	// ****************************************************************
	rbiws_pkg::rbiws_state_type state_reg, state_next;
	logic [11:0] cnt_reg, cnt_next, wake_lat;
	logic [9:0] wd_cnt_reg, wd_cnt_next;
	logic wd_active_reg, wd_active_next, rst_cause, wake;
	logic pll_dis_reg, pll_dis_next, micro_reg, micro_next;
	logic core_rst_next, bus_next, booted_next, resume_next;
	logic [3:0] boot_mode_next;
	assign status = '{BOOT_MODE_OUT, micro_reg, IDLE_ACTIVE, BOOT_SAMPLED, pll_dis_reg,
		PLL_LOCKED};
	// the pin reaches here after the synchroniser, so release is on a CLK edge
	assign rst_cause = ~pins.reset_pin_n | wd_active_reg;
	assign wake = ENABLED_IRQ | WATCHDOG_INTERRUPT | nmi_q;
	// latency counted from the qualified wake, so the qualifier time adds on top
	assign wake_lat = sys_to_clk(fsleep_reg ? rbiws_pkg::WAKE_SLOW_SYS
		: rbiws_pkg::WAKE_FAST_SYS, pll_dis_reg);
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg + 12'h001;
		wd_active_next = wd_active_reg;
		wd_cnt_next = wd_active_reg ? wd_cnt_reg + 10'h001 : 10'h000;
		pll_dis_next = pll_dis_reg;
		micro_next = micro_reg;
		core_rst_next = 1'b0;
		bus_next = EXT_BUS_VALID;
		booted_next = BOOT_SAMPLED;
		boot_mode_next = BOOT_MODE_OUT;
		resume_next = 1'b0;
		if (WATCHDOG_EXPIRE && !wd_active_reg)
		begin
			wd_active_next = 1'b1;
			wd_cnt_next = 10'h000;
		end
		else if (wd_active_reg && wd_cnt_reg == rbiws_pkg::WD_PULSE_CYC - 10'h001)
			wd_active_next = 1'b0;
		case (state_reg)
			rbiws_pkg::ST_RESET:
			begin
				core_rst_next = 1'b1;
				cnt_next = 12'h000;
				// straps caught on the release edge; pin low means PLL off
				if (!rst_cause)
				begin
					state_next = rbiws_pkg::ST_BOOT;
					core_rst_next = 1'b0;
					pll_dis_next = ~pins.pll_disable_strap;
					micro_next = pins.micro_mode_strap;
				end
			end
			rbiws_pkg::ST_BOOT:
			begin
				if (cnt_reg == rbiws_pkg::EXT_BUS_CYC - 12'h001)
					bus_next = 1'b1;
				if (cnt_reg == sys_to_clk(rbiws_pkg::BOOT_SYS, pll_dis_reg) - 12'h001)
				begin
					booted_next = 1'b1;
					boot_mode_next = pins.boot_mode;
					state_next = rbiws_pkg::ST_RUN;
				end
			end
			rbiws_pkg::ST_RUN:
				if (idle_req_reg)
					state_next = rbiws_pkg::ST_IDLE;
			rbiws_pkg::ST_IDLE:
			begin
				cnt_next = 12'h000;
				if (wake)
					state_next = rbiws_pkg::ST_WAKE;
			end
			rbiws_pkg::ST_WAKE:
				if (cnt_reg == wake_lat - 12'h001)
				begin
					resume_next = 1'b1;
					state_next = rbiws_pkg::ST_RUN;
				end
			default:
				state_next = rbiws_pkg::ST_RESET;
		endcase
		if (rst_cause)
		begin
			state_next = rbiws_pkg::ST_RESET;
			core_rst_next = 1'b1;
			bus_next = 1'b0;
			booted_next = 1'b0;
			cnt_next = 12'h000;
		end
	end
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			state_reg <= rbiws_pkg::ST_RESET;
			cnt_reg <= 12'h000;
			wd_active_reg <= 1'b0;
			wd_cnt_reg <= 10'h000;
			pll_dis_reg <= 1'b0;
			micro_reg <= 1'b0;
			CORE_RESET <= 1'b1;
			EXT_BUS_VALID <= 1'b0;
			BOOT_SAMPLED <= 1'b0;
			BOOT_MODE_OUT <= 4'h0;
			IDLE_ACTIVE <= 1'b0;
			RESUME <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			wd_active_reg <= wd_active_next;
			wd_cnt_reg <= wd_cnt_next;
			pll_dis_reg <= pll_dis_next;
			micro_reg <= micro_next;
			CORE_RESET <= core_rst_next;
			EXT_BUS_VALID <= bus_next;
			BOOT_SAMPLED <= booted_next;
			BOOT_MODE_OUT <= boot_mode_next;
			IDLE_ACTIVE <= state_next == rbiws_pkg::ST_IDLE;
			RESUME <= resume_next;
		end
	end
	// ****************************************************************
	// clock out divider
	// ****************************************************************
	logic [3:0] co_half, co_cnt_reg, co_cnt_next;
	logic co_next;
	// system clock (CLK/2 at most), then /2 per set divide bit; after reset both bits give /4
	always_comb
	begin
		co_half = (pll_dis_reg ? 4'h1 : 4'h2) << extif_reg[0] << extif_reg[1];
		co_half = co_half >> 1;
		if (co_half == 4'h0)
			co_half = 4'h1;
		co_cnt_next = co_cnt_reg + 4'h1;
		co_next = CLOCK_OUT_PIN;
		if (co_cnt_reg >= co_half - 4'h1)
		begin
			co_cnt_next = 4'h0;
			co_next = ~CLOCK_OUT_PIN;
		end
	end
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			co_cnt_reg <= 4'h0;
			CLOCK_OUT_PIN <= 1'b0;
		end
		else
		begin
			co_cnt_reg <= co_cnt_next;
			CLOCK_OUT_PIN <= co_next;
		end
	end
	// ****************************************************************
	// checks
	// ****************************************************************
	chk_lock_time: assert property (
		lock_busy_reg && lock_cnt_reg == 18'(LOCK_CYC - 1) |=> ##1 PLL_LOCKED)
		else $error("PLL lock not reported on time");
	// pulse length counted in helper logic: too long for a repetition or a delay
	logic [10:0] wd_len_reg, wd_len_next;
	always_comb
	begin
		wd_len_next = wd_active_reg ? wd_len_reg + 11'h001 : 11'h000;
	end
	always_ff @(posedge CLK)
	begin
		if (RST)
			wd_len_reg <= 11'h000;
		else
			wd_len_reg <= wd_len_next;
	end
	chk_wd_pulse_len: assert property (
		$fell(wd_active_reg) || (wd_len_reg > {1'b0, rbiws_pkg::WD_PULSE_CYC}) |->
		wd_len_reg == {1'b0, rbiws_pkg::WD_PULSE_CYC})
		else $error("watchdog reset pulse length wrong");
	chk_reset_hold: assert property (
		rst_cause |=> CORE_RESET && !EXT_BUS_VALID)
		else $error("core reset not held");
	chk_bus_valid_time: assert property (
		$fell(CORE_RESET) |-> !EXT_BUS_VALID[*8] ##24 !EXT_BUS_VALID ##1 EXT_BUS_VALID)
		else $error("bus valid not 32 clocks after release");
	chk_boot_sample: assert property (
		$rose(BOOT_SAMPLED) |-> $past(cnt_reg) == sys_to_clk(rbiws_pkg::BOOT_SYS, pll_dis_reg)
		- 12'h001)
		else $error("boot pins sampled at wrong time");
	chk_clkout_div: assert property (
		$rose(CLOCK_OUT_PIN) && co_half == 4'h4 |-> CLOCK_OUT_PIN[*4] ##1 !CLOCK_OUT_PIN)
		else $error("clock out not system clock over four");
	chk_clkout_min: assert property (
		$rose(CLOCK_OUT_PIN) |=> CLOCK_OUT_PIN || co_half == 4'h1)
		else $error("clock out faster than input clock over two");
	chk_wake_fast: assert property (
		state_reg == rbiws_pkg::ST_IDLE && wake && !rst_cause && !fsleep_reg && !pll_dis_reg
		|=> ##16 RESUME)
		else $error("fast wake latency wrong");
	chk_wake_enter: assert property (
		state_reg == rbiws_pkg::ST_IDLE && wake && !rst_cause |=> state_reg == rbiws_pkg::ST_WAKE)
		else $error("idle not left on wake source");
	chk_pll_off: assert property (
		pll_dis_reg |-> !PLL_LOCKED && !lock_busy_reg)
		else $error("disabled PLL reports lock");
	cov_wd_reset: cover property ($fell(wd_active_reg));
	cov_boot: cover property ($rose(BOOT_SAMPLED));
	cov_resume: cover property (RESUME);
	cov_lock: cover property ($rose(PLL_LOCKED));
endmodule : rbiws_top
`default_nettype wire

// [tb/rbiws_far.sv]
// Purpose: far side model: reset source, wake pin, strap and boot pins
// Assumes: pins change just after a rising clk edge
// Notes: straps and boot pins never move, the simplest way to keep holds
`timescale 1ns/10ps
`default_nettype none
module rbiws_far
(
	input wire logic clk,
	output var rbiws_pkg::rbiws_pins_type pins
);
	// ****************************************************************
	// pin drivers
	// ****************************************************************
	// power-up: pin low, plls on, boot code 4'hA, straps fixed for good
	initial pins = '{1'b0, 1'b0, 1'b1, 1'b0, 4'hA};

	// warm reset; the clock runs freely long before release
	task automatic pulse_reset(input int n);
		@(posedge clk);
		pins.reset_pin_n <= 1'b0;
		repeat (n) @(posedge clk);
		pins.reset_pin_n <= 1'b1;
	endtask : pulse_reset

	// wake pulse, never shorter than two system cycles
	task automatic wake_nmi(input int n);
		@(posedge clk);
		pins.nmi <= 1'b1;
		repeat (n) @(posedge clk);
		pins.nmi <= 1'b0;
	endtask : wake_nmi
endmodule : rbiws_far
`default_nettype wire

// [tb/tb.sv]
// Purpose: self-checking bench of the reset, boot and wake sequencer
// Assumes: 25 MHz clk, short lock count of 20
// Notes: the wait task looks at outputs 1 ns after each edge; the bus tasks look at them on the edge
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam int unsigned LK = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic irq = 1'b0, wdi = 1'b0, wdx = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h00000000, rd, d;
	logic [3:0] wst = 4'hF, bm;
	logic awr, wr, bv, arr, rv, cr, ebv, bs, pl, co, ia, res;
	logic [1:0] br, rr, r;
	logic [6:0] obs;
	rbiws_pkg::rbiws_pins_type pins;
	int failures = 0, n_tests = 0, cyc = 0, n;

	// ****************************************************************
	// clock, instances, watchdog on the run
	// ****************************************************************
	always #20 clk = ~clk;
	assign obs = {res, ia, co, pl, bs, ebv, cr};
	rbiws_far i_rbiws_far (.clk(clk), .pins(pins));
	rbiws_top #(.LOCK_CYC(LK)) i_rbiws_top (.CLK(clk), .RST(rst),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(wst),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_BRESP(br),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
		.PINS(pins), .ENABLED_IRQ(irq), .WATCHDOG_INTERRUPT(wdi),
		.WATCHDOG_EXPIRE(wdx), .CORE_RESET(cr), .EXT_BUS_VALID(ebv),
		.BOOT_SAMPLED(bs), .BOOT_MODE_OUT(bm), .PLL_LOCKED(pl),
		.CLOCK_OUT_PIN(co), .IDLE_ACTIVE(ia), .RESUME(res));

	// a hang ends the run as a mismatch; the tests need under 8000 cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			finish_test();
		end
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic finish_test;
		$display("failures=%0d n_tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	// address and data offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] q);
		@(posedge clk);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wr)
				wv <= 1'b0;
		end
		while (!bv);
		bry <= 1'b0;
		q = br;
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] q);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arr)
				arv <= 1'b0;
		end
		while (!rv);
		rry <= 1'b0;
		v = rd;
		q = rr;
	endtask : axr

	// counts edges until output i shows lvl; bounded so a stuck flag cannot hang
	task automatic wt(input int i, input logic lvl, output int k);
		k = 0;
		do
		begin
			@(posedge clk);
			#1;
			k++;
		end
		while (obs[i] !== lvl && k < 5000);
	endtask : wt

	// ****************************************************************
	// tests
	// ****************************************************************
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		#1;
		chk(cr, 1'b1);
		i_rbiws_far.pulse_reset(10);
		wt(0, 1'b0, n);
		chk(n <= 6, 1'b1);
		wt(1, 1'b1, n);
		chk(n, 32);
		wt(2, 1'b1, n);
		chk(n + 32 >= 2520 && n + 32 <= 2523, 1'b1);
		chk(bm, 4'hA);
		axr(rbiws_pkg::OFS_EXTIF, d, r);
		chk(d, {30'h0, rbiws_pkg::EXTIF_RESET});
		axr(rbiws_pkg::OFS_PLLMUL, d, r);
		chk(d, 32'h00000000);
		axr(8'h14, d, r);
		chk(r, rbiws_pkg::RESP_SLVERR);
		wt(4, 1'b1, n);
		wt(4, 1'b0, n);
		chk(n, 4);
		wt(4, 1'b1, n);
		chk(n, 4);
		chk(pl, 1'b0);
		// both divide bits cleared: clock out follows the system clock, CLK/2
		axw(rbiws_pkg::OFS_EXTIF, 32'h00000000, r);
		wt(4, 1'b1, n);
		wt(4, 1'b0, n);
		chk(n, 1);
		axw(rbiws_pkg::OFS_PLLMUL, 32'h00000003, r);
		chk(r, rbiws_pkg::RESP_OKAY);
		wt(3, 1'b1, n);
		chk(n <= LK + 4, 1'b1);
		axr(rbiws_pkg::OFS_STATUS, d, r);
		chk(d[8:0], 9'h145);
		axw(rbiws_pkg::OFS_QUAL, 32'h00000001, r);
		axr(rbiws_pkg::OFS_QUAL, d, r);
		chk(d, 32'h00000001);
		// sources: irq, watchdog interrupt, nmi, irq with flash asleep, qualified nmi
		for (int k = 0; k < 5; k++)
		begin
			axw(rbiws_pkg::OFS_CTRL, (k == 3) ? 32'h00000005 : (k == 4) ? 32'h00000003
				: 32'h00000001, r);
			wt(5, 1'b1, n);
			chk(n <= 4, 1'b1);
			@(posedge clk);
			irq <= (k == 0 || k == 3);
			wdi <= (k == 1);
			// the qualified pulse outlasts six sample periods of four clocks
			if (k == 2 || k == 4)
				i_rbiws_far.wake_nmi((k == 4) ? 40 : 8);
			wt(6, 1'b1, n);
			chk((k == 3) ? (n > 17 && n <= 2102)
				: (n <= ((k == 2) ? 14 : (k == 4) ? 8 : 17)), 1'b1);
			@(posedge clk);
			irq <= 1'b0;
			wdi <= 1'b0;
			#1;
			chk(ia, 1'b0);
		end
		axr(rbiws_pkg::OFS_CTRL, d, r);
		chk(d, 32'h00000002);
		@(posedge clk);
		wdx <= 1'b1;
		@(posedge clk);
		wdx <= 1'b0;
		wt(0, 1'b1, n);
		wt(0, 1'b0, n);
		chk(n >= 511 && n <= 513, 1'b1);
		wt(1, 1'b1, n);
		chk(n, 32);
		finish_test();
	end
endmodule : tb
`default_nettype wire
